/* shared/bfsp_pkg.sv */
// shared constants and carrier types for the boot flash section protection
package bfsp_pkg;
    // flash word address width and page word-select width
    localparam int AW     = 13;
    localparam int PAGE_W = 5;

    // register byte offsets
    localparam logic [3:0] REG_LOCK  = 4'h0;
    localparam logic [3:0] REG_CFG   = 4'h4;
    localparam logic [3:0] REG_STAT  = 4'h8;
    localparam logic [3:0] REG_ERASE = 4'hC;

    // lock register fields, 1 = unprogrammed
    localparam int LK_APP_WR  = 0;
    localparam int LK_APP_RD  = 1;
    localparam int LK_BOOT_WR = 2;
    localparam int LK_BOOT_RD = 3;
    localparam logic [3:0] LOCK_RST = 4'hF;

    // config register fields
    localparam int CFG_BSZ = 0;
    localparam int CFG_VEC = 2;
    localparam logic [1:0] BSZ_RST = 2'h3;

    // status register fields
    localparam int ST_BUSY = 0;
    localparam int ST_PROG = 1;
    localparam int ST_HALT = 2;

    localparam logic [7:0] ERASE_KEY = 8'hE5;

    typedef enum logic { OP_ERASE, OP_WRITE } bfsp_op_t;
    typedef enum logic { PS_IDLE, PS_PROG } bfsp_pst_t;

    typedef struct packed {
        logic            valid;
        bfsp_op_t        op;
        logic [AW-1:0]   page_addr;
        logic [AW-1:0]   exec_addr;
    } bfsp_spm_req_t;

    typedef struct packed {
        logic            done;
        logic            refused;
    } bfsp_spm_rsp_t;

    typedef struct packed {
        logic            valid;
        logic [AW:0]     byte_addr;
        logic [AW-1:0]   exec_addr;
    } bfsp_lpm_req_t;

    typedef struct packed {
        logic            valid;
        logic            refused;
        logic [7:0]      data;
    } bfsp_lpm_rsp_t;

    typedef struct packed {
        logic            start;
        bfsp_op_t        op;
        logic [AW-1:0]   page_addr;
    } bfsp_fcmd_t;

    typedef struct packed {
        logic            ack;
        logic [31:0]     rdata;
        logic [3:0]      locks;
        logic [1:0]      bsz;
        logic            vec_boot;
        logic            busy;
        bfsp_pst_t       pst;
        logic            non_rewritable_section;
        bfsp_fcmd_t      fcmd;
        bfsp_spm_rsp_t   spm_rsp;
        bfsp_lpm_rsp_t   lpm_rsp;
        logic            irq_mask;
    } bfsp_state_t;
endpackage : bfsp_pkg

/* src/bfsp_top.sv */
// boot flash section protection and read-while-write arbitration
`timescale 1ns/10ps

// Operation
// - store from application section is ignored, never starts programming
// - programming starts only for a store executed from the boot section
// - boot-section store may target any page, boot pages included
// - boot size fuses set the section boundary; each section has own locks
// - rewritable-section operation keeps core running, other section readable
// - non-rewritable-section operation halts core for its whole duration
// - rewritable section unreadable during programming; software avoids it
// - busy flag reads one while rewritable-section reads are blocked
// - boot section always lies inside the non-rewritable section
// - lock bits programmed by software or programmer, cleared by erase only
// - general write lock does not stop store-driven programming
// - general read/write lock does not restrict load or store
// - application locks both one: no application access restriction
// - application write lock zero refuses stores to application section
// - application read lock zero refuses boot-code loads of application
// - application read lock zero masks boot vectors while in application
// - boot locks both one: no boot section access restriction
// - boot write lock zero refuses stores to boot section
// - boot read lock zero refuses application-code loads of boot section
// - boot read lock zero masks application vectors while in boot code
// - target page latched at start decides which section is busy
module bfsp_top #(
    parameter int NON_REWRITABLE_SECTION_WORDS     = 1024,
    parameter int BOOT_MIN_WORDS = 128
) (
    // clock and reset
    input  wire logic                   core_clk,
    input  wire logic                   rst_n,
    // avalon-mm register slave
    input  wire logic [3:0]             avs_address,
    input  wire logic                   avs_read,
    input  wire logic                   avs_write,
    input  wire logic [31:0]            avs_writedata,
    input  wire logic [3:0]             avs_byteenable,
    output logic      [31:0]            avs_readdata,
    output logic                        avs_waitrequest,
    // core program-memory requests
    input  wire bfsp_pkg::bfsp_spm_req_t spm_req,
    output bfsp_pkg::bfsp_spm_rsp_t      spm_rsp,
    input  wire bfsp_pkg::bfsp_lpm_req_t lpm_req,
    output bfsp_pkg::bfsp_lpm_rsp_t      lpm_rsp,
    // core fetch and execution state
    input  wire logic [bfsp_pkg::AW-1:0] fetch_addr,
    input  wire logic [bfsp_pkg::AW-1:0] core_pc,
    output logic                        fetch_blocked,
    output logic                        core_halt,
    output logic                        irq_mask,
    // flash array
    output bfsp_pkg::bfsp_fcmd_t         flash_cmd,
    input  wire logic                   flash_done,
    output logic      [bfsp_pkg::AW:0]  flash_rd_addr,
    input  wire logic [7:0]             flash_rd_data
);
    localparam int FLASH_WORDS = 1 << bfsp_pkg::AW;
    localparam logic [bfsp_pkg::AW-1:0] NON_REWRITABLE_SECTION_START =
        bfsp_pkg::AW'(FLASH_WORDS - NON_REWRITABLE_SECTION_WORDS);

    // largest boot size is eight times the smallest; it must stay non-rewritable
    if (BOOT_MIN_WORDS * 8 > NON_REWRITABLE_SECTION_WORDS) begin : g_boot_fit
        $error("boot section larger than non-rewritable section");
    end
    if (NON_REWRITABLE_SECTION_WORDS >= FLASH_WORDS || BOOT_MIN_WORDS < 1) begin : g_size_ok
        $error("section sizes out of range");
    end

    logic [1:0] rst_sync;
    logic       rst_n_sync;

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_sync <= 2'h0;
        end else begin
            rst_sync <= {rst_sync[0], 1'b1};
        end
    end
    assign rst_n_sync = rst_sync[1];

    // first word of the boot section for a fuse setting
    function automatic logic [bfsp_pkg::AW-1:0] boot_start(
        input logic [1:0] bsz
    );
        int words;
        words = BOOT_MIN_WORDS << (2'h3 - bsz);
        return bfsp_pkg::AW'(FLASH_WORDS - words);
    endfunction : boot_start

    function automatic logic in_boot(
        input logic [bfsp_pkg::AW-1:0] a,
        input logic [1:0]              bsz
    );
        return a >= boot_start(bsz);
    endfunction : in_boot

    function automatic logic in_non_rewritable_section(input logic [bfsp_pkg::AW-1:0] a);
        return a >= NON_REWRITABLE_SECTION_START;
    endfunction : in_non_rewritable_section

    bfsp_pkg::bfsp_state_t r_reg;
    bfsp_pkg::bfsp_state_t r_next;

    logic                  req;
    logic                  wr_go;
    logic [bfsp_pkg::AW-1:0] spm_page;
    logic                  spm_tgt_boot;
    logic                  spm_exec_boot;
    logic                  spm_locked;
    logic [bfsp_pkg::AW-1:0] lpm_word;
    logic                  lpm_tgt_boot;
    logic                  lpm_exec_boot;
    logic                  lpm_locked;
    logic                  lpm_rww_hit;
    logic                  pc_boot;

    assign req      = avs_read | avs_write;
    assign wr_go    = avs_write & r_reg.ack & avs_byteenable[0];
    assign spm_page = {spm_req.page_addr[bfsp_pkg::AW-1:bfsp_pkg::PAGE_W],
                       bfsp_pkg::PAGE_W'(0)};
    assign spm_tgt_boot  = in_boot(spm_page, r_reg.bsz);
    assign spm_exec_boot = in_boot(spm_req.exec_addr, r_reg.bsz);
    assign lpm_word      = lpm_req.byte_addr[bfsp_pkg::AW:1];
    assign lpm_tgt_boot  = in_boot(lpm_word, r_reg.bsz);
    assign lpm_exec_boot = in_boot(lpm_req.exec_addr, r_reg.bsz);
    assign pc_boot       = in_boot(core_pc, r_reg.bsz);

    // general lock modes take no part in these terms
    // all-ones locks give no term below a chance to refuse
    assign spm_locked =
        (!spm_tgt_boot && !r_reg.locks[bfsp_pkg::LK_APP_WR]) ||
        (spm_tgt_boot && !r_reg.locks[bfsp_pkg::LK_BOOT_WR]);

    assign lpm_locked =
        (lpm_exec_boot && !lpm_tgt_boot &&
         !r_reg.locks[bfsp_pkg::LK_APP_RD]) ||
        (!lpm_exec_boot && lpm_tgt_boot &&
         !r_reg.locks[bfsp_pkg::LK_BOOT_RD]);

    assign lpm_rww_hit = r_reg.busy && !in_non_rewritable_section(lpm_word);

    always_comb begin
        r_next = r_reg;
        r_next.ack = req & ~r_reg.ack;
        r_next.fcmd.start = 1'b0;
        r_next.spm_rsp = '0;
        r_next.lpm_rsp = '0;

        // register read, answered one cycle later
        if (avs_read && !r_reg.ack) begin
            r_next.rdata = 32'h0;
            case (avs_address)
                bfsp_pkg::REG_LOCK: begin
                    r_next.rdata[3:0] = r_reg.locks;
                end
                bfsp_pkg::REG_CFG: begin
                    r_next.rdata[bfsp_pkg::CFG_BSZ +: 2] = r_reg.bsz;
                    r_next.rdata[bfsp_pkg::CFG_VEC] = r_reg.vec_boot;
                end
                bfsp_pkg::REG_STAT: begin
                    r_next.rdata[bfsp_pkg::ST_BUSY] = r_reg.busy;
                    r_next.rdata[bfsp_pkg::ST_PROG] =
                        (r_reg.pst == bfsp_pkg::PS_PROG);
                    r_next.rdata[bfsp_pkg::ST_HALT] = core_halt;
                end
                default: begin
                    r_next.rdata = 32'h0;
                end
            endcase
        end

        // register write takes effect at the edge that completes it
        if (wr_go) begin
            case (avs_address)
                bfsp_pkg::REG_LOCK: begin
                    // writes can only program bits to zero
                    r_next.locks = r_reg.locks & avs_writedata[3:0];
                end
                bfsp_pkg::REG_CFG: begin
                    // boundary must not move under a running operation
                    if (r_reg.pst == bfsp_pkg::PS_IDLE) begin
                        r_next.bsz = avs_writedata[bfsp_pkg::CFG_BSZ +: 2];
                        r_next.vec_boot = avs_writedata[bfsp_pkg::CFG_VEC];
                    end
                end
                bfsp_pkg::REG_STAT: begin
                    if (avs_writedata[bfsp_pkg::ST_BUSY] &&
                        r_reg.pst == bfsp_pkg::PS_IDLE) begin
                        r_next.busy = 1'b0;
                    end
                end
                bfsp_pkg::REG_ERASE: begin
                    if (avs_writedata[7:0] == bfsp_pkg::ERASE_KEY) begin
                        r_next.locks = bfsp_pkg::LOCK_RST;
                    end
                end
                default: begin
                    r_next.locks = r_next.locks;
                end
            endcase
        end

        // programming sequencer
        case (r_reg.pst)
            bfsp_pkg::PS_IDLE: begin
                if (spm_req.valid) begin
                    if (!spm_exec_boot) begin
                        r_next.spm_rsp.refused = 1'b1;
                    end else if (spm_locked) begin
                        r_next.spm_rsp.refused = 1'b1;
                    end else begin
                        r_next.pst = bfsp_pkg::PS_PROG;
                        r_next.fcmd.start = 1'b1;
                        r_next.fcmd.op = spm_req.op;
                        r_next.fcmd.page_addr = spm_page;
                        r_next.non_rewritable_section = in_non_rewritable_section(spm_page);
                        // a start beats a software clear in the same cycle
                        if (!in_non_rewritable_section(spm_page)) begin
                            r_next.busy = 1'b1;
                        end
                    end
                end
            end
            bfsp_pkg::PS_PROG: begin
                if (spm_req.valid) begin
                    r_next.spm_rsp.refused = 1'b1;
                end
                if (flash_done) begin
                    r_next.pst = bfsp_pkg::PS_IDLE;
                    r_next.spm_rsp.done = 1'b1;
                end
            end
            default: begin
                r_next.pst = bfsp_pkg::PS_IDLE;
            end
        endcase

        // program-memory load
        if (lpm_req.valid) begin
            r_next.lpm_rsp.valid = 1'b1;
            if (lpm_locked || lpm_rww_hit) begin
                r_next.lpm_rsp.refused = 1'b1;
                r_next.lpm_rsp.data = 8'h00;
            end else begin
                r_next.lpm_rsp.data = flash_rd_data;
            end
        end

        // vectors in the other section are masked while the running section is read-locked
        r_next.irq_mask =
            (!pc_boot && r_reg.vec_boot &&
             !r_reg.locks[bfsp_pkg::LK_APP_RD]) ||
            (pc_boot && !r_reg.vec_boot &&
             !r_reg.locks[bfsp_pkg::LK_BOOT_RD]);
    end

    always_ff @(posedge core_clk or negedge rst_n_sync) begin
        if (!rst_n_sync) begin
            r_reg <= '{ack: 1'b0, rdata: 32'h0,
                       locks: bfsp_pkg::LOCK_RST,
                       bsz: bfsp_pkg::BSZ_RST, vec_boot: 1'b0,
                       busy: 1'b0, pst: bfsp_pkg::PS_IDLE,
                       non_rewritable_section: 1'b0, fcmd: '0, spm_rsp: '0,
                       lpm_rsp: '0, irq_mask: 1'b0};
        end else begin
            r_reg <= r_next;
        end
    end

    assign avs_waitrequest = req & ~r_reg.ack;
    assign avs_readdata    = r_reg.rdata;
    assign spm_rsp         = r_reg.spm_rsp;
    assign lpm_rsp         = r_reg.lpm_rsp;
    assign flash_cmd       = r_reg.fcmd;
    assign flash_rd_addr   = lpm_req.byte_addr;
    assign irq_mask        = r_reg.irq_mask;
    // rewritable target keeps the core running; the other halts it
    assign core_halt = (r_reg.pst == bfsp_pkg::PS_PROG) &&
                       r_reg.non_rewritable_section;
    assign fetch_blocked = r_reg.busy && !in_non_rewritable_section(fetch_addr);

    // ---- checks
    logic erase_wr;
    assign erase_wr = wr_go && avs_address == bfsp_pkg::REG_ERASE &&
                      avs_writedata[7:0] == bfsp_pkg::ERASE_KEY;

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n_sync);

    a_app_spm_ignored: assert property (
        spm_req.valid && !spm_exec_boot |=>
            spm_rsp.refused && !flash_cmd.start)
        else $error("store from application section not refused");

    a_start_from_boot: assert property (
        flash_cmd.start |->
            $past(spm_req.valid) && $past(spm_exec_boot))
        else $error("programming started without boot store");

    a_rww_no_halt: assert property (
        flash_cmd.start && !in_non_rewritable_section(flash_cmd.page_addr) |->
            !core_halt && fetch_blocked == !in_non_rewritable_section(fetch_addr))
        else $error("rewritable operation halted core");

    a_non_rewritable_section_halt_hold: assert property (
        (flash_cmd.start && in_non_rewritable_section(flash_cmd.page_addr) |-> core_halt) and
        (core_halt && !flash_done |=> core_halt))
        else $error("core not halted through operation");

    a_halt_ends_done: assert property (
        $fell(core_halt) |-> $past(flash_done))
        else $error("halt released before operation done");

    a_lpm_rww_block: assert property (
        lpm_req.valid && lpm_rww_hit |=>
            lpm_rsp.refused && lpm_rsp.data == 8'h00)
        else $error("rewritable read not blocked");

    a_busy_flag_set: assert property (
        flash_cmd.start && !in_non_rewritable_section(flash_cmd.page_addr) |->
            r_reg.busy ##1 r_reg.busy)
        else $error("busy flag not set for rewritable operation");

    a_app_wr_lock: assert property (
        spm_req.valid && !spm_tgt_boot &&
        !r_reg.locks[bfsp_pkg::LK_APP_WR] |=> !flash_cmd.start)
        else $error("locked application write started");

    a_boot_wr_lock: assert property (
        spm_req.valid && spm_tgt_boot &&
        !r_reg.locks[bfsp_pkg::LK_BOOT_WR] |=> !flash_cmd.start)
        else $error("locked boot write started");

    a_boot_rd_lock: assert property (
        lpm_req.valid && !lpm_exec_boot && lpm_tgt_boot &&
        !r_reg.locks[bfsp_pkg::LK_BOOT_RD] |=> lpm_rsp.refused)
        else $error("locked boot read allowed");

    a_app_rd_lock: assert property (
        lpm_req.valid && lpm_exec_boot && !lpm_tgt_boot &&
        !r_reg.locks[bfsp_pkg::LK_APP_RD] |=> lpm_rsp.refused)
        else $error("locked application read allowed");

    a_irq_app_mask: assert property (
        !pc_boot && r_reg.vec_boot &&
        !r_reg.locks[bfsp_pkg::LK_APP_RD] |=> irq_mask)
        else $error("boot vectors not masked in application");

    a_irq_boot_mask: assert property (
        pc_boot && !r_reg.vec_boot &&
        !r_reg.locks[bfsp_pkg::LK_BOOT_RD] |=> irq_mask)
        else $error("application vectors not masked in boot code");

    a_busy_clear_idle: assert property (
        $fell(r_reg.busy) |-> $past(r_reg.pst) == bfsp_pkg::PS_IDLE)
        else $error("busy flag cleared during programming");

    a_lock_sticky: assert property (
        (r_reg.locks & ~$past(r_reg.locks)) != 4'h0 |->
            $past(erase_wr))
        else $error("lock bit cleared without erase");

    a_page_latched: assert property (
        flash_cmd.start |=>
            $stable(flash_cmd.page_addr) && $stable(r_reg.non_rewritable_section))
        else $error("latched page changed");

    c_rww_program: cover property (
        flash_cmd.start && !r_reg.non_rewritable_section ##[1:50] flash_done);
    c_non_rewritable_section_program: cover property (
        flash_cmd.start && r_reg.non_rewritable_section ##[1:50] flash_done);
    c_lpm_refused: cover property (lpm_rsp.refused);
    c_busy_cleared: cover property ($fell(r_reg.busy));

endmodule : bfsp_top

/* sim/bfsp_flash_model.sv */
// flash array model: times program commands and serves byte reads
`timescale 1ns/10ps
module bfsp_flash_model (
    // clock and reset
    input  wire logic                 core_clk,
    input  wire logic                 rst_n,
    // program command side
    input  wire bfsp_pkg::bfsp_fcmd_t fcmd,
    input  wire logic [7:0]           lat,
    output logic                      done,
    // byte read side
    input  wire logic [13:0]          rd_addr,
    output logic [7:0]                rd_data
);
    logic [7:0] cnt_reg;

    // reads answer in the same cycle, the block samples them at once
    assign rd_data = rd_addr[7:0] ^ {2'h0, rd_addr[13:8]};

    // lat sets prompt or slow completion of each program command
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_reg <= 8'h00;
            done    <= 1'b0;
        end else begin
            done <= (cnt_reg == 8'h01);
            if (fcmd.start) begin
                cnt_reg <= lat;
            end else if (cnt_reg != 8'h00) begin
                cnt_reg <= cnt_reg - 8'h01;
            end
        end
    end
endmodule : bfsp_flash_model

/* sim/bfsp_top_test.sv */
// self-checking bench for the boot flash section protection block
`timescale 1ns/10ps
module bfsp_top_test;
    localparam logic [12:0] BX = 13'h1F90;
    logic                    core_clk = 1'b0;
    logic                    rst_n = 1'b0;
    logic [3:0]              avs_address = 4'h0;
    logic                    avs_read = 1'b0;
    logic                    avs_write = 1'b0;
    logic [31:0]             avs_writedata = 32'h0;
    logic [3:0]              avs_byteenable = 4'hF;
    logic [31:0]             avs_readdata;
    logic                    avs_waitrequest;
    bfsp_pkg::bfsp_spm_req_t spm_req = '0;
    bfsp_pkg::bfsp_spm_rsp_t spm_rsp;
    bfsp_pkg::bfsp_lpm_req_t lpm_req = '0;
    bfsp_pkg::bfsp_lpm_rsp_t lpm_rsp;
    logic [12:0]             fetch_addr = BX;
    logic [12:0]             core_pc = BX;
    logic                    fetch_blocked;
    logic                    core_halt;
    logic                    irq_mask;
    bfsp_pkg::bfsp_fcmd_t    flash_cmd;
    logic                    flash_done;
    logic [13:0]             flash_rd_addr;
    logic [7:0]              flash_rd_data;
    logic [7:0]              lat = 8'h01;
    logic [12:0]             bs;
    logic [13:0]             ra;
    int                      miscompares = 0;
    int                      check_count = 0;
    int                      starts = 0;
    int                      exp_starts = 0;
    int                      seed = 32'h7EC8;
    logic [31:0]             expq[1:3][$];

    always #12.5 core_clk = ~core_clk;

    bfsp_top u_bfsp_top (.core_clk(core_clk), .rst_n(rst_n),
        .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .spm_req(spm_req),
        .spm_rsp(spm_rsp), .lpm_req(lpm_req), .lpm_rsp(lpm_rsp),
        .fetch_addr(fetch_addr), .core_pc(core_pc),
        .fetch_blocked(fetch_blocked), .core_halt(core_halt),
        .irq_mask(irq_mask), .flash_cmd(flash_cmd),
        .flash_done(flash_done), .flash_rd_addr(flash_rd_addr),
        .flash_rd_data(flash_rd_data));

    bfsp_flash_model u_bfsp_flash_model (.core_clk(core_clk),
        .rst_n(rst_n), .fcmd(flash_cmd), .lat(lat), .done(flash_done),
        .rd_addr(flash_rd_addr), .rd_data(flash_rd_data));

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            miscompares++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task automatic end_sim();
        $display("checks=%0d mismatches=%0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : end_sim

    task automatic pop(input int k, input logic [31:0] seen);
        if (expq[k].size() == 0) begin
            miscompares++;
        end else begin
            check(seen, expq[k].pop_front());
        end
    endtask : pop

    // results are matched per kind, they arrive out of issue order
    // sampled mid-cycle, where every registered output has settled
    always @(negedge core_clk) begin
        if (flash_cmd.start) begin
            starts++;
        end
        if (spm_rsp.done || spm_rsp.refused) begin
            pop(1, {30'h0, spm_rsp});
        end
        if (lpm_rsp.valid) begin
            pop(2, {23'h0, lpm_rsp.refused, lpm_rsp.data});
        end
        if (avs_read && !avs_waitrequest) begin
            pop(3, avs_readdata);
        end
    end

    task automatic cyc(input int n);
        repeat (n) @(posedge core_clk);
    endtask : cyc

    task automatic bus(input logic [3:0] a, input logic r,
                       input logic [31:0] d);
        int n;
        n = 0;
        @(posedge core_clk);
        avs_address <= a;
        avs_read <= r;
        avs_write <= !r;
        avs_writedata <= d;
        do begin
            @(posedge core_clk);
            n++;
        end while (avs_waitrequest && n < 50);
        if (avs_waitrequest) begin
            miscompares++;
        end
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask : bus

    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        bus(a, 1'b0, d);
    endtask : wr

    task automatic rd(input logic [3:0] a, input logic [31:0] e);
        expq[3].push_back(e);
        bus(a, 1'b1, 32'h0);
    endtask : rd

    // page bit 0 picks erase or write; the block ignores the word bits
    task automatic spm(input logic [12:0] pg, input logic [12:0] ex,
                       input logic ok, input logic [7:0] l);
        expq[1].push_back({30'h0, ok, !ok});
        exp_starts += ok;
        @(posedge core_clk);
        lat <= l;
        spm_req <= '{1'b1, bfsp_pkg::bfsp_op_t'(pg[0]), pg, ex};
        @(posedge core_clk);
        spm_req.valid <= 1'b0;
    endtask : spm

    task automatic spm_wait();
        int n;
        n = 0;
        do begin
            @(posedge core_clk);
            n++;
        end while (!(spm_rsp.done || spm_rsp.refused) && n < 200);
        if (n >= 200) begin
            miscompares++;
        end
    endtask : spm_wait

    task automatic lpm(input logic [13:0] a, input logic [12:0] ex,
                       input logic ok);
        expq[2].push_back(ok ? {24'h0, a[7:0] ^ {2'h0, a[13:8]}} : 32'h100);
        @(posedge core_clk);
        lpm_req <= '{1'b1, a, ex};
        @(posedge core_clk);
        lpm_req.valid <= 1'b0;
    endtask : lpm

    task automatic lvl(input logic s, input logic e);
        check({31'h0, s}, {31'h0, e});
    endtask : lvl

    task automatic tdone(input int t);
        cyc(3);
        check(starts, exp_starts);
        for (int k = 1; k <= 3; k++) begin
            check(expq[k].size(), 0);
        end
        $display("test %0d done", t);
    endtask : tdone

    initial begin
        #1000000;
        miscompares++;
        end_sim();
    end

    initial begin
        repeat (5) @(posedge core_clk);
        rst_n <= 1'b1;
        cyc(3);
        rd(bfsp_pkg::REG_LOCK, 32'hF);
        rd(bfsp_pkg::REG_CFG, 32'h3);
        rd(bfsp_pkg::REG_STAT, 32'h0);
        rd(4'h1, 32'h0);
        spm(13'h0041, 13'h0100, 1'b0, 8'h01);
        spm_wait();
        tdone(1);
        spm(13'h0041, BX, 1'b1, 8'h50);
        cyc(2);
        fetch_addr <= 13'h0010;
        cyc(1);
        lvl(fetch_blocked, 1'b1);
        lvl(core_halt, 1'b0);
        fetch_addr <= 13'h1C00;
        cyc(1);
        lvl(fetch_blocked, 1'b0);
        rd(bfsp_pkg::REG_STAT, 32'h3);
        lpm(14'h0020, BX, 1'b0);
        lpm(14'h3900, BX, 1'b1);
        wr(bfsp_pkg::REG_STAT, 32'h1);
        spm_wait();
        rd(bfsp_pkg::REG_STAT, 32'h1);
        // software clears the busy flag before returning to that code
        wr(bfsp_pkg::REG_STAT, 32'h1);
        rd(bfsp_pkg::REG_STAT, 32'h0);
        fetch_addr <= 13'h0010;
        cyc(1);
        lvl(fetch_blocked, 1'b0);
        tdone(2);
        spm(13'h1FC0, BX, 1'b1, 8'h50);
        cyc(3);
        lvl(core_halt, 1'b1);
        check({24'h0, flash_cmd.page_addr[12:5]}, 32'hFE);
        check({31'h0, flash_cmd.op}, 32'h0);
        spm_wait();
        cyc(2);
        lvl(core_halt, 1'b0);
        tdone(3);
        for (int b = 0; b < 4; b++) begin
            bs = 13'(8192 - (128 << (3 - b)));
            wr(bfsp_pkg::REG_CFG, 32'(b));
            spm(13'h1C00, bs - 13'h1, 1'b0, 8'h01);
            spm_wait();
            spm(13'h1C00, bs, 1'b1, 8'h01);
            spm_wait();
        end
        wr(bfsp_pkg::REG_CFG, 32'h3);
        tdone(4);
        wr(bfsp_pkg::REG_LOCK, 32'hE);
        spm(13'h0040, BX, 1'b0, 8'h01);
        spm_wait();
        spm(13'h1FC1, BX, 1'b1, 8'h01);
        spm_wait();
        wr(bfsp_pkg::REG_LOCK, 32'hB);
        spm(13'h1FC0, BX, 1'b0, 8'h01);
        spm_wait();
        wr(bfsp_pkg::REG_LOCK, 32'hF);
        rd(bfsp_pkg::REG_LOCK, 32'hA);
        lpm(14'h0080, BX, 1'b1);
        wr(bfsp_pkg::REG_LOCK, 32'hD);
        lpm(14'h0080, BX, 1'b0);
        lpm(14'h0080, 13'h0100, 1'b1);
        wr(bfsp_pkg::REG_CFG, 32'h7);
        core_pc <= 13'h0100;
        cyc(3);
        lvl(irq_mask, 1'b1);
        core_pc <= BX;
        cyc(3);
        lvl(irq_mask, 1'b0);
        wr(bfsp_pkg::REG_LOCK, 32'h7);
        lpm(14'h3F00, 13'h0100, 1'b0);
        wr(bfsp_pkg::REG_CFG, 32'h3);
        cyc(3);
        lvl(irq_mask, 1'b1);
        // a write with its low byte lane off must leave the locks alone
        avs_byteenable <= 4'hE;
        wr(bfsp_pkg::REG_ERASE, 32'hE5);
        avs_byteenable <= 4'hF;
        rd(bfsp_pkg::REG_LOCK, 32'h0);
        wr(bfsp_pkg::REG_ERASE, 32'hE5);
        rd(bfsp_pkg::REG_LOCK, 32'hF);
        tdone(5);
        repeat (8) begin
            ra = {3'h7, 11'($random(seed))};
            lpm(ra, 13'h0100, 1'b1);
        end
        tdone(6);
        end_sim();
    end
endmodule : bfsp_top_test
